// ===== fcr_pkg.sv
/*
 * Package for the flash CPU rewrite control block: register map, field positions,
 * reset values, enumerations and carrier structs.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package fcr_pkg;

    localparam logic [7:0] FCR_ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] FCR_ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] FCR_ADDR_PROT = 8'h08;
    localparam logic [7:0] FCR_ADDR_STAT = 8'h0c;

    localparam int FCR_B_READY = 0;
    localparam int FCR_B_REWR = 1;
    localparam int FCR_B_LOCKOVR = 2;
    localparam int FCR_B_STOP = 3;
    localparam int FCR_B_AREA = 5;
    localparam int FCR_B_PERR = 6;
    localparam int FCR_B_EERR = 7;
    localparam int FCR_B_MODE2 = 1;

    localparam int FCR_B_PM0 = 0;
    localparam int FCR_B_PM3 = 3;

    localparam logic [1:0] FCR_PROT_LVL_OFF = 2'h3;
    localparam logic [1:0] FCR_PROT_RM_OPEN = 2'h0;
    localparam logic [7:0] FCR_PROT_ERASED = 8'hff;
    localparam int FCR_PROT_LVL_LSB = 6;
    localparam int FCR_PROT_RM_LSB = 4;

    localparam logic [7:0] FCR_CTRL0_RST = 8'h01;
    localparam logic [7:0] FCR_CTRL1_RST = 8'h00;
    localparam logic [3:0] FCR_NBLK = 4'h8;

    typedef enum logic [1:0] {
        FCR_OP_PROG = 2'b00,
        FCR_OP_ERASE = 2'b01,
        FCR_OP_LOCK = 2'b10,
        FCR_OP_RDSR = 2'b11
    } fcr_op_t;

    typedef enum logic [1:0] {
        FCR_ST_IDLE = 2'b00,
        FCR_ST_BUSY = 2'b01,
        FCR_ST_DONE = 2'b10
    } fcr_state_t;

    typedef enum logic [1:0] {
        FCR_ARM_IDLE = 2'b00,
        FCR_ARM_ZERO = 2'b01
    } fcr_arm_t;

    typedef struct packed {
        logic valid;
        fcr_op_t op;
        logic [2:0] blk;
        logic boot_area;
    } fcr_cmd_t;

    typedef struct packed {
        logic done;
        logic fail;
    } fcr_rsp_t;

endpackage

// ===== fcr_arm.sv
/*
 * Two-write arming of one control bit: a write of 0 followed directly by a
 * write of 1 to the same register sets the bit when allow_i is high; a lone 1 does nothing.
 * Assumes wr_i pulses once per register write, with the written bit on bit_i.
 */
`timescale 1ns/1ps
module fcr_arm
    import fcr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic wr_i,
    input wire logic bit_i,
    input wire logic allow_i,
    input wire logic force_clr_i,
    output logic set_o
);

    fcr_arm_t arm_r;
    fcr_arm_t arm_nxt;
    logic set_nxt;

    always_comb begin
        arm_nxt = arm_r;
        set_nxt = set_o;
        if (force_clr_i) begin
            arm_nxt = FCR_ARM_IDLE;
            set_nxt = 1'b0;
        end else if (wr_i) begin
            case (arm_r)
                FCR_ARM_IDLE: begin
                    if (!bit_i) begin
                        arm_nxt = FCR_ARM_ZERO;
                        set_nxt = 1'b0;
                    end
                end
                FCR_ARM_ZERO: begin
                    arm_nxt = FCR_ARM_IDLE;
                    if (bit_i && allow_i) begin
                        set_nxt = 1'b1;
                    end
                end
                default: arm_nxt = FCR_ARM_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            arm_r <= FCR_ARM_IDLE;
            set_o <= 1'b0;
        end else begin
            arm_r <= arm_nxt;
            set_o <= set_nxt;
        end
    end

endmodule

// ===== fcr_ctrl.sv
/*
 * Flash CPU rewrite control: APB register file, mode arming, command gating,
 * busy/error flags, lock override, flash stop and protect byte evaluation.
 * Assumes a flash array engine answering each issued command with done/fail,
 * and pins for boot mode, parallel mode and low power mode.
 */
`timescale 1ns/1ps
module fcr_ctrl
    import fcr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boot_mode_i,
    input wire logic par_mode_i,
    input wire logic low_pwr_i,
    input wire fcr_cmd_t cmd_i,
    input wire logic [7:0] pm_user_i,
    input wire fcr_rsp_t rsp_i,
    input wire logic [7:0] prot_wr_data_i,
    input wire logic prot_wr_i,
    output fcr_cmd_t cmd_o,
    output logic cmd_refused_o,
    output logic cpu_hold_o,
    output logic [7:0] pm_eff_o,
    output logic flash_pwr_o,
    output logic flash_init_o,
    output logic rd_status_sel_o,
    output logic par_access_ok_o,
    output logic [FCR_NBLK-1:0] lock_eff_o
);

    logic [2:0] bm_s_r;
    logic [2:0] pm_s_r;
    logic [2:0] lp_s_r;
    logic low_pwr_q;
    logic boot_q;
    logic par_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bm_s_r <= 3'h0;
            pm_s_r <= 3'h0;
            lp_s_r <= 3'h0;
            boot_q <= 1'b0;
            par_q <= 1'b0;
            low_pwr_q <= 1'b0;
        end else begin
            bm_s_r <= {bm_s_r[1:0], boot_mode_i};
            pm_s_r <= {pm_s_r[1:0], par_mode_i};
            lp_s_r <= {lp_s_r[1:0], low_pwr_i};
            if (bm_s_r[1] == bm_s_r[2]) boot_q <= bm_s_r[2];
            if (pm_s_r[1] == pm_s_r[2]) par_q <= pm_s_r[2];
            if (lp_s_r[1] == lp_s_r[2]) low_pwr_q <= lp_s_r[2];
        end
    end

    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite;
    wire wr_ctrl0 = apb_wr && (paddr == FCR_ADDR_CTRL0);
    wire wr_ctrl1 = apb_wr && (paddr == FCR_ADDR_CTRL1);
    wire wr_prot = apb_wr && (paddr == FCR_ADDR_PROT);
    wire addr_ok = (paddr == FCR_ADDR_CTRL0) || (paddr == FCR_ADDR_CTRL1) ||
                   (paddr == FCR_ADDR_PROT) || (paddr == FCR_ADDR_STAT);

    logic rewr_en;
    logic mode2;
    logic lockovr_r;
    logic stop_r;
    logic area_r;
    logic perr_r;
    logic eerr_r;
    logic busy_r;
    fcr_op_t op_r;
    logic [2:0] blk_r;
    logic [7:0] prot_r;
    logic [FCR_NBLK-1:0] lock_r;
    logic [6:0] pad_r;
    fcr_state_t st_r;
    wire rewr_drop = !rewr_en || (wr_ctrl0 && !pwdata[FCR_B_REWR]);

    fcr_arm u_arm_rewr (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_ctrl0),
        .bit_i(pwdata[FCR_B_REWR]),
        .allow_i(1'b1),
        .force_clr_i(1'b0),
        .set_o(rewr_en)
    );

    fcr_arm u_arm_mode2 (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_ctrl1),
        .bit_i(pwdata[FCR_B_MODE2]),
        .allow_i(rewr_en),
        .force_clr_i(rewr_drop),
        .set_o(mode2)
    );

    wire ram_mode = rewr_en && !mode2;
    wire rom_mode = rewr_en && mode2;
    wire stop_eff = stop_r && rewr_en;
    wire user_ok = !boot_q || area_r;
    wire blk_locked = !lock_r[cmd_i.blk] && !lockovr_r;

    function automatic logic cmd_legal(input fcr_cmd_t c, input logic rom, input logic lk);
        cmd_legal = !c.boot_area && !(c.op == FCR_OP_RDSR && rom);
        if ((c.op == FCR_OP_PROG || c.op == FCR_OP_ERASE) && lk) cmd_legal = 1'b0;
    endfunction

    wire cmd_take = cmd_i.valid && rewr_en && !stop_eff && !busy_r && user_ok &&
                    cmd_legal(cmd_i, rom_mode, blk_locked);
    wire cmd_bad = cmd_i.valid && !cmd_take;
    wire starts_op = cmd_take && (cmd_i.op != FCR_OP_RDSR);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= FCR_ST_IDLE;
            busy_r <= 1'b0;
            op_r <= FCR_OP_PROG;
            blk_r <= 3'h0;
        end else begin
            case (st_r)
                FCR_ST_IDLE, FCR_ST_DONE: begin
                    if (starts_op) begin
                        st_r <= FCR_ST_BUSY;
                        busy_r <= 1'b1;
                        op_r <= cmd_i.op;
                        blk_r <= cmd_i.blk;
                    end else begin
                        st_r <= FCR_ST_IDLE;
                    end
                end
                FCR_ST_BUSY: begin
                    if (stop_eff) begin
                        st_r <= FCR_ST_IDLE;
                        busy_r <= 1'b0;
                    end else if (rsp_i.done) begin
                        st_r <= FCR_ST_DONE;
                        busy_r <= 1'b0;
                    end
                end
                default: begin
                    st_r <= FCR_ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    wire op_end = (st_r == FCR_ST_BUSY) && rsp_i.done && !stop_eff;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lockovr_r <= 1'b0;
            stop_r <= 1'b0;
            area_r <= 1'b0;
            pad_r <= 7'h00;
        end else begin
            if (wr_ctrl0) begin
                lockovr_r <= pwdata[FCR_B_LOCKOVR];
                stop_r <= pwdata[FCR_B_STOP];
                area_r <= pwdata[FCR_B_AREA];
            end
            if (wr_ctrl1) pad_r <= {pwdata[7:2], pwdata[0]};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            perr_r <= 1'b0;
            eerr_r <= 1'b0;
        end else if (stop_eff) begin
            perr_r <= 1'b0;
            eerr_r <= 1'b0;
        end else if (op_end) begin
            perr_r <= (op_r == FCR_OP_PROG) && rsp_i.fail;
            eerr_r <= (op_r == FCR_OP_ERASE) && rsp_i.fail;
        end
    end

    wire erase_ok = op_end && (op_r == FCR_OP_ERASE) && !rsp_i.fail;
    wire prot_blk = blk_r == 3'h7;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock_r <= '0;
            prot_r <= FCR_PROT_ERASED;
        end else begin
            if (erase_ok && lockovr_r) lock_r[blk_r] <= 1'b1;
            else if (op_end && op_r == FCR_OP_LOCK && !rsp_i.fail) lock_r[blk_r] <= 1'b0;
            if (erase_ok && prot_blk) prot_r <= FCR_PROT_ERASED;
            else if (prot_wr_i) prot_r <= prot_wr_data_i;
            else if (wr_prot && !par_q) prot_r <= pwdata[7:0];
        end
    end

    wire [1:0] prot_lvl = prot_r[FCR_PROT_LVL_LSB+:2];
    wire [1:0] prot_rm = prot_r[FCR_PROT_RM_LSB+:2];
    wire protected_w = (prot_lvl != FCR_PROT_LVL_OFF) && (prot_rm != FCR_PROT_RM_OPEN);

    wire [7:0] ctrl0_rd = {eerr_r, perr_r, area_r, 1'b0, stop_r, lockovr_r, rewr_en, !busy_r};
    wire [7:0] ctrl1_rd = {pad_r[6:1], mode2, pad_r[0]};
    wire [7:0] stat_rd = {3'h0, protected_w, rom_mode, ram_mode, boot_q, par_q};

    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            FCR_ADDR_CTRL0: rd_mux = {24'h0, ctrl0_rd};
            FCR_ADDR_CTRL1: rd_mux = {24'h0, ctrl1_rd};
            FCR_ADDR_PROT: rd_mux = {24'h0, prot_r};
            FCR_ADDR_STAT: rd_mux = {24'h0, stat_rd};
            default: rd_mux = 32'h0;
        endcase
    end

    wire [7:0] pm_forced = pm_user_i | (8'h01 << FCR_B_PM0) | (8'h01 << FCR_B_PM3);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            cmd_o <= '0;
            cmd_refused_o <= 1'b0;
            cpu_hold_o <= 1'b0;
            pm_eff_o <= 8'h00;
            flash_pwr_o <= 1'b0;
            flash_init_o <= 1'b1;
            rd_status_sel_o <= 1'b0;
            par_access_ok_o <= 1'b0;
            lock_eff_o <= '0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (psel && !penable && !pwrite) prdata <= rd_mux;
            cmd_o <= starts_op ? cmd_i : '0;
            cmd_refused_o <= cmd_bad;
            cpu_hold_o <= rom_mode && (starts_op || busy_r) && !stop_eff;
            pm_eff_o <= rewr_en ? pm_forced : pm_user_i;
            flash_pwr_o <= !stop_eff && !low_pwr_q;
            flash_init_o <= stop_eff;
            if (cmd_take && cmd_i.op == FCR_OP_RDSR) rd_status_sel_o <= 1'b1;
            else if (op_end) rd_status_sel_o <= ram_mode;
            else if (!rewr_en || rom_mode) rd_status_sel_o <= 1'b0;
            par_access_ok_o <= par_q && !protected_w;
            lock_eff_o <= lockovr_r ? {FCR_NBLK{1'b1}} : lock_r;
        end
    end

    // Remembers whether the latest enable register write cleared the enable bit.
    logic last0_r;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last0_r <= 1'b0;
        end else if (wr_ctrl0) begin
            last0_r <= !pwdata[FCR_B_REWR];
        end
    end

    sequence seq_rom_start;
        rom_mode && starts_op;
    endsequence

    sequence seq_prot_erase;
        erase_ok && prot_blk;
    endsequence

    AST_LONE_ONE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (!rewr_en && wr_ctrl0 && pwdata[FCR_B_REWR] && !last0_r) |=> !rewr_en)
        else $error("rewrite enable set by a lone write");
    AST_ROM_NEEDS_EN: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        mode2 |-> rewr_en) else $error("rom mode without rewrite enable");
    AST_BUSY_READY: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        starts_op |=> busy_r ##0 !ctrl0_rd[FCR_B_READY]) else $error("ready not cleared");
    AST_PERR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (op_end && op_r == FCR_OP_PROG && rsp_i.fail) |=> perr_r)
        else $error("program error not flagged");
    AST_EERR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (op_end && op_r == FCR_OP_ERASE && rsp_i.fail) |=> eerr_r)
        else $error("erase error not flagged");
    AST_NO_BOOT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (cmd_i.valid && cmd_i.boot_area) |=> cmd_o == '0 ##0 cmd_refused_o)
        else $error("boot area command accepted");
    AST_PROT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (prot_rm == FCR_PROT_RM_OPEN) |-> !protected_w) else $error("removal ignored");
    AST_PM: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        rewr_en |=> pm_eff_o[FCR_B_PM0] && pm_eff_o[FCR_B_PM3])
        else $error("processor mode bits not forced");
    AST_UNLOCK: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (erase_ok && lockovr_r) |=> lock_r[$past(blk_r)]) else $error("lock not cleared");
    AST_ROM_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        seq_rom_start |=> cpu_hold_o) else $error("cpu not held in rom mode");
    AST_RAM_RUN: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        ram_mode |=> !cpu_hold_o) else $error("cpu held in ram mode");
    AST_ROM_RDSR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (cmd_i.valid && cmd_i.op == FCR_OP_RDSR && rom_mode) |=> cmd_refused_o)
        else $error("status read accepted in rom mode");
    AST_LOCKED: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (cmd_i.valid && cmd_i.op == FCR_OP_PROG && !lock_r[cmd_i.blk] && !lockovr_r)
        |=> cmd_refused_o) else $error("locked block programmed");
    AST_AREA: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (cmd_i.valid && boot_q && !area_r) |=> cmd_refused_o)
        else $error("boot mode command without user area");
    AST_STOP_ABORT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (stop_eff && st_r == FCR_ST_BUSY) |=> !busy_r) else $error("stop did not abort");
    AST_PROT_ERASE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        seq_prot_erase |=> prot_r == FCR_PROT_ERASED) else $error("protect byte kept");
    AST_PWR_OFF: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        low_pwr_q |=> !flash_pwr_o) else $error("flash powered in low power");

endmodule

// ===== fcr_ctrl_tb.sv
/*
 * Self-checking testbench for the flash CPU rewrite control block.
 * Assumes the package register map and a single-cycle APB access.
 */
`timescale 1ns/1ps
module fcr_ctrl_tb
    import fcr_pkg::*;
;
    logic clk_sys_i;
    logic rst_b_i;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic boot_mode_i;
    logic par_mode_i;
    logic low_pwr_i;
    fcr_cmd_t cmd_i;
    logic [7:0] pm_user_i;
    fcr_rsp_t rsp_i;
    logic [7:0] prot_wr_data_i;
    logic prot_wr_i;
    fcr_cmd_t cmd_o;
    logic cmd_refused_o;
    logic cpu_hold_o;
    logic [7:0] pm_eff_o;
    logic flash_pwr_o;
    logic flash_init_o;
    logic rd_status_sel_o;
    logic par_access_ok_o;
    logic [FCR_NBLK-1:0] lock_eff_o;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    fcr_ctrl fcr_ctrl_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_mode_i(boot_mode_i),
        .par_mode_i(par_mode_i), .low_pwr_i(low_pwr_i), .cmd_i(cmd_i),
        .pm_user_i(pm_user_i), .rsp_i(rsp_i), .prot_wr_data_i(prot_wr_data_i),
        .prot_wr_i(prot_wr_i), .cmd_o(cmd_o), .cmd_refused_o(cmd_refused_o),
        .cpu_hold_o(cpu_hold_o), .pm_eff_o(pm_eff_o), .flash_pwr_o(flash_pwr_o),
        .flash_init_o(flash_init_o), .rd_status_sel_o(rd_status_sel_o),
        .par_access_ok_o(par_access_ok_o), .lock_eff_o(lock_eff_o));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The run is cut short if it hangs.
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        tests_run = tests_run + 1;
        if (s !== x) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, x);
    endtask

    task automatic cmd(input fcr_op_t o, input logic [2:0] b, input logic ba,
            input logic ok);
        fcr_cmd_t c;
        c = '{valid: 1'b1, op: o, blk: b, boot_area: ba};
        @(posedge clk_sys_i);
        cmd_i <= c;
        @(posedge clk_sys_i);
        cmd_i <= '0;
        #1;
        chk(32'(cmd_o), ok ? 32'(c) : 32'h0);
        chk(32'(cmd_refused_o), 32'(!ok));
    endtask

    task automatic fin(input logic f);
        @(posedge clk_sys_i);
        rsp_i <= '{done: 1'b1, fail: f};
        @(posedge clk_sys_i);
        rsp_i <= '0;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic s_reset();
        logic [31:0] r;
        logic e;
        rd(FCR_ADDR_CTRL0, 32'hffffffff, {24'h0, FCR_CTRL0_RST});
        rd(FCR_ADDR_CTRL1, 32'hffffffff, {24'h0, FCR_CTRL1_RST});
        rd(FCR_ADDR_PROT, 32'hffffffff, 32'h000000ff);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        chk({flash_pwr_o, flash_init_o, pm_eff_o}, 10'h242);
        cmd(FCR_OP_PROG, 3'h1, 1'b0, 1'b0);
    endtask

    task automatic s_arm();
        wr(FCR_ADDR_CTRL0, 8'h02);
        rd(FCR_ADDR_CTRL0, 32'hff, 32'h01);
        wr(FCR_ADDR_CTRL0, 8'h00);
        wr(FCR_ADDR_CTRL0, 8'h02);
        rd(FCR_ADDR_CTRL0, 32'hff, 32'h03);
        chk(pm_eff_o, 8'h4b);
        wr(FCR_ADDR_CTRL1, 8'h02);
        rd(FCR_ADDR_CTRL1, 32'hff, 32'h00);
    endtask

    task automatic s_ram();
        wr(FCR_ADDR_CTRL0, 8'h06);
        cmd(FCR_OP_PROG, 3'h1, 1'b0, 1'b1);
        chk(cpu_hold_o, 1'b0);
        rd(FCR_ADDR_CTRL0, 32'hff, 32'h06);
        fin(1'b1);
        rd(FCR_ADDR_CTRL0, 32'hff, 32'h47);
        chk(rd_status_sel_o, 1'b1);
        cmd(FCR_OP_ERASE, 3'h4, 1'b0, 1'b1);
        fin(1'b1);
        rd(FCR_ADDR_CTRL0, 32'h80, 32'h80);
    endtask

    task automatic s_prot();
        logic [7:0] pv[4] = '{8'h30, 8'h00, 8'hf0, 8'h70};
        logic ok[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        par_mode_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        for (int i = 0; i < 4; i++) begin
            prot_wr_data_i <= pv[i];
            prot_wr_i <= 1'b1;
            @(posedge clk_sys_i);
            prot_wr_i <= 1'b0;
            repeat (3) @(posedge clk_sys_i);
            chk(par_access_ok_o, ok[i]);
        end
        par_mode_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        cmd(FCR_OP_ERASE, 3'h7, 1'b0, 1'b1);
        fin(1'b0);
        rd(FCR_ADDR_PROT, 32'hffffffff, {24'h0, FCR_PROT_ERASED});
        chk(lock_eff_o[7], 1'b1);
    endtask

    task automatic s_lock();
        wr(FCR_ADDR_CTRL0, 8'h02);
        cmd(FCR_OP_PROG, 3'h2, 1'b0, 1'b0);
        chk(lock_eff_o, 8'h80);
        cmd(FCR_OP_PROG, 3'h7, 1'b0, 1'b1);
        fin(1'b0);
        rd(FCR_ADDR_CTRL0, 32'hff, 32'h03);
        cmd(FCR_OP_PROG, 3'h7, 1'b1, 1'b0);
    endtask

    task automatic s_rom();
        wr(FCR_ADDR_CTRL1, 8'h00);
        wr(FCR_ADDR_CTRL1, 8'h02);
        rd(FCR_ADDR_CTRL1, 32'hff, 32'h02);
        cmd(FCR_OP_RDSR, 3'h7, 1'b0, 1'b0);
        cmd(FCR_OP_PROG, 3'h7, 1'b0, 1'b1);
        chk(cpu_hold_o, 1'b1);
        fin(1'b0);
        chk({cpu_hold_o, rd_status_sel_o}, 2'b00);
        wr(FCR_ADDR_CTRL1, 8'h00);
    endtask

    task automatic s_stop();
        cmd(FCR_OP_PROG, 3'h7, 1'b0, 1'b1);
        wr(FCR_ADDR_CTRL0, 8'h0a);
        repeat (2) @(posedge clk_sys_i);
        chk(flash_init_o, 1'b1);
        rd(FCR_ADDR_CTRL0, 32'hff, 32'h0b);
        cmd(FCR_OP_PROG, 3'h7, 1'b0, 1'b0);
        wr(FCR_ADDR_CTRL0, 8'h02);
        repeat (2) @(posedge clk_sys_i);
        chk(flash_init_o, 1'b0);
        low_pwr_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        chk(flash_pwr_o, 1'b0);
        low_pwr_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk(flash_pwr_o, 1'b1);
    endtask

    task automatic s_boot();
        boot_mode_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        cmd(FCR_OP_PROG, 3'h7, 1'b0, 1'b0);
        wr(FCR_ADDR_CTRL0, 8'h22);
        cmd(FCR_OP_PROG, 3'h7, 1'b0, 1'b1);
        fin(1'b0);
        cmd(FCR_OP_LOCK, 3'h7, 1'b0, 1'b1);
        rd(FCR_ADDR_CTRL0, 32'hff, 32'h22);
        fin(1'b0);
        chk(lock_eff_o, 8'h00);
        boot_mode_i <= 1'b0;
    endtask

    initial begin
        rst_b_i = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {boot_mode_i, par_mode_i, low_pwr_i, prot_wr_i, prot_wr_data_i} = '0;
        cmd_i = '0;
        rsp_i = '0;
        pm_user_i = 8'h42;
        repeat (5) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        s_reset();
        s_arm();
        s_ram();
        s_prot();
        s_lock();
        s_rom();
        s_stop();
        s_boot();
        summarize();
    end
endmodule
